// ---- src/fsr_defs.svh ----
// Purpose: Shared constants of the flow sensor read-out port.
// Assumes: Included by bare name; definitions only.
// Notes:   Timing counts are derived in the modules from these rates.
`ifndef FSR_DEFS_SVH
`define FSR_DEFS_SVH

`define FSR_CLK_HZ      50000000
`define FSR_SCL_HZ      100000
`define FSR_SCL_MAX_HZ  400000
`define FSR_QTR_MIN     4
`define FSR_DEV_ADDR    7'h50
`define FSR_DIR_READ    1'b1
`define FSR_BIT_ACK     1'b0
`define FSR_BIT_NACK    1'b1
`define FSR_BITS        4'h8
`define FSR_HI_PAD      4'h0
`define FSR_CHK_OK      8'h00
`define FSR_FILL_BYTE   8'hFF
`define FSR_FLOW_W      12
`define FSR_IDX_CHK     3'h0
`define FSR_IDX_HI0     3'h1
`define FSR_IDX_LO0     3'h2
`define FSR_IDX_HI1     3'h3
`define FSR_IDX_LO1     3'h4
`define FSR_IDX_LAST    3'h5
`define FSR_BUF_DEPTH   2

`endif

// ---- src/fsr_pkg.sv ----
// Purpose: State types of both ends of the flow sensor read-out port.
// Assumes: Referenced as fsr_pkg::name, never imported.
// Notes:   Binary codes are written out.
package fsr_pkg;

   typedef enum logic [2:0] {
      SLV_IDLE    = 3'h0,
      SLV_ADDR    = 3'h1,
      SLV_ADDRACK = 3'h2,
      SLV_TX      = 3'h3,
      SLV_TXACK   = 3'h4,
      SLV_RX      = 3'h5,
      SLV_RXACK   = 3'h6,
      SLV_TXNEXT  = 3'h7
   } fsr_slv_e;

   typedef enum logic [1:0] {
      MST_IDLE  = 2'h0,
      MST_START = 2'h1,
      MST_BIT   = 2'h2,
      MST_STOP  = 2'h3
   } fsr_mst_e;

endpackage

// ---- src/fsr_if.sv ----
// Purpose: Two-wire link between the bus master and the flow sensor.
// Assumes: SDA is open drain with a pull-up; SCL is driven by the master only.
// Notes:   The wire level is resolved here from the drivers' enables.
`timescale 1ns/100ps
interface fsr_if;
   logic scl;
   logic sdaMOut;
   logic sdaMOe;
   logic sdaSOut;
   logic sdaSOe;
   logic sda;

   // The pull-up holds the line high unless a driver pulls it low.
   assign sda = ~((sdaMOe & ~sdaMOut) | (sdaSOe & ~sdaSOut));

   modport master (output scl, output sdaMOut, output sdaMOe, input sda);
   modport slave  (input scl, input sda, output sdaSOut, output sdaSOe);
endinterface

// ---- src/fsr_buf.sv ----
// Purpose: Small valid/ready buffer for measurement words.
// Assumes: Same clock on both sides.
// Notes:   Depth must be a power of two, at least two.
`timescale 1ns/100ps
module fsr_buf #(
   parameter int W     = 12,
   parameter int DEPTH = 2
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         clkEn,
   input  wire logic [W-1:0] inData,
   input  wire logic         inValid,
   output logic              inReady,
   output logic [W-1:0]      outData,
   output logic              outValid,
   input  wire logic         outReady
);
   localparam int PW = $clog2(DEPTH);

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
      $error("fsr_buf depth must be a power of two of at least two");
   end

   logic [W-1:0]  mem [DEPTH];
   logic [PW-1:0] wrPtr_r;
   logic [PW-1:0] rdPtr_r;
   logic [PW:0]   count_r;
   wire           push = inValid & inReady;
   wire           pop  = outValid & outReady;

   assign inReady  = count_r != DEPTH[PW:0];
   assign outValid = count_r != '0;
   assign outData  = mem[rdPtr_r];

   always_ff @(posedge clk) begin
      if (clkEn && push) begin
         mem[wrPtr_r] <= inData;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
         count_r <= '0;
      end else if (clkEn) begin
         wrPtr_r <= wrPtr_r + PW'(push);
         rdPtr_r <= rdPtr_r + PW'(pop);
         count_r <= count_r + (PW+1)'(push) - (PW+1)'(pop);
      end
   end
endmodule

// ---- src/fsr_slave.sv ----
// Purpose: Sensor end of the two-wire read-out port: answers reads of the flow value.
// Assumes: clk is much faster than SCL (at least eight clk periods per SCL period).
// Notes:   SCL and SDA pass two flip-flops before use; edges are found on clk.
`timescale 1ns/100ps
`include "fsr_defs.svh"
module fsr_slave #(
   parameter int BUF_DEPTH = `FSR_BUF_DEPTH
) (
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   input  wire logic                   clkEn,
   fsr_if.slave                        bus,
   input  wire logic [`FSR_FLOW_W-1:0] measData,
   input  wire logic                   measValid,
   output logic                        measReady,
   output logic                        readActive
);
   fsr_pkg::fsr_slv_e state_r;
   fsr_pkg::fsr_slv_e state_nxt;
   logic [1:0]              sclSync_r;
   logic [1:0]              sdaSync_r;
   logic                    sclPrev_r;
   logic                    sdaPrev_r;
   logic [3:0]              bitCnt_r;
   logic [3:0]              bitCnt_nxt;
   logic [7:0]              shift_r;
   logic [7:0]              shift_nxt;
   logic [2:0]              byteIdx_r;
   logic [2:0]              byteIdx_nxt;
   logic                    dirRead_r;
   logic                    dirRead_nxt;
   logic                    pull_r;
   logic                    pull_nxt;
   logic [`FSR_FLOW_W-1:0]  flow_r;
   logic [`FSR_FLOW_W-1:0]  bufData;
   logic                    bufValid;

   // Edges are taken from the second synchroniser stage and its delayed copy.
   wire       sclNow    = sclSync_r[1];
   wire       sdaNow    = sdaSync_r[1];
   wire       sclRise   = sclNow & ~sclPrev_r;
   wire       sclFall   = ~sclNow & sclPrev_r;
   wire       startSeen = sclNow & sclPrev_r & sdaPrev_r & ~sdaNow;
   wire       stopSeen  = sclNow & sclPrev_r & ~sdaPrev_r & sdaNow;
   wire       byteDone  = bitCnt_r == `FSR_BITS;
   wire       addrHit   = shift_r[7:1] == `FSR_DEV_ADDR;

   // Both data pairs repeat the same snapshot, so the four summed bytes agree.
   wire [7:0] hiByte    = {`FSR_HI_PAD, flow_r[11:8]};
   wire [7:0] loByte    = flow_r[7:0];
   wire [7:0] dataSum   = hiByte + loByte + hiByte + loByte;
   wire [7:0] chkByte   = `FSR_CHK_OK - dataSum;
   wire       selChk    = byteIdx_r == `FSR_IDX_CHK;
   wire       selHi     = byteIdx_r == `FSR_IDX_HI0 || byteIdx_r == `FSR_IDX_HI1;
   wire       selLo     = byteIdx_r == `FSR_IDX_LO0 || byteIdx_r == `FSR_IDX_LO1;
   // Past the fifth byte the line is left released, which reads as all ones.
   wire [7:0] txByte    = selChk ? chkByte :
                          selHi  ? hiByte  :
                          selLo  ? loByte  : `FSR_FILL_BYTE;

   // The snapshot is frozen from the address acknowledge to the end of the read.
   assign readActive = state_r != fsr_pkg::SLV_IDLE && state_r != fsr_pkg::SLV_ADDR;
   assign bus.sdaSOut = 1'b0;
   assign bus.sdaSOe  = pull_r;

   fsr_buf #(
      .W     (`FSR_FLOW_W),
      .DEPTH (BUF_DEPTH)
   ) u_buf (
      .clk      (clk),
      .rst_n    (rst_n),
      .clkEn    (clkEn),
      .inData   (measData),
      .inValid  (measValid),
      .inReady  (measReady),
      .outData  (bufData),
      .outValid (bufValid),
      .outReady (~readActive)
   );

   always_comb begin
      state_nxt   = state_r;
      bitCnt_nxt  = bitCnt_r;
      shift_nxt   = shift_r;
      byteIdx_nxt = byteIdx_r;
      dirRead_nxt = dirRead_r;
      pull_nxt    = pull_r;
      if (startSeen) begin
         // A repeated START restarts address reception at once.
         state_nxt  = fsr_pkg::SLV_ADDR;
         bitCnt_nxt = 4'h0;
         pull_nxt   = 1'b0;
      end else if (stopSeen) begin
         state_nxt = fsr_pkg::SLV_IDLE;
         pull_nxt  = 1'b0;
      end else begin
         case (state_r)
            fsr_pkg::SLV_ADDR, fsr_pkg::SLV_RX: begin
               if (sclRise && !byteDone) begin
                  shift_nxt  = {shift_r[6:0], sdaNow};
                  bitCnt_nxt = bitCnt_r + 4'h1;
               end else if (sclFall && byteDone) begin
                  bitCnt_nxt = 4'h0;
                  if (state_r == fsr_pkg::SLV_RX) begin
                     pull_nxt  = 1'b1;
                     state_nxt = fsr_pkg::SLV_RXACK;
                  end else if (addrHit) begin
                     pull_nxt    = 1'b1;
                     dirRead_nxt = shift_r[0] == `FSR_DIR_READ;
                     state_nxt   = fsr_pkg::SLV_ADDRACK;
                  end else begin
                     state_nxt = fsr_pkg::SLV_IDLE;
                  end
               end
            end
            fsr_pkg::SLV_RXACK: begin
               // Written bytes are acknowledged and discarded.
               if (sclFall) begin
                  pull_nxt  = 1'b0;
                  state_nxt = fsr_pkg::SLV_RX;
               end
            end
            fsr_pkg::SLV_ADDRACK, fsr_pkg::SLV_TXNEXT: begin
               if (sclFall) begin
                  bitCnt_nxt = 4'h0;
                  if (state_r == fsr_pkg::SLV_ADDRACK && !dirRead_r) begin
                     pull_nxt  = 1'b0;
                     state_nxt = fsr_pkg::SLV_RX;
                  end else begin
                     pull_nxt    = ~txByte[7];
                     shift_nxt   = {txByte[6:0], 1'b0};
                     byteIdx_nxt = byteIdx_r + 3'h1;
                     state_nxt   = fsr_pkg::SLV_TX;
                  end
               end
            end
            fsr_pkg::SLV_TX: begin
               if (sclRise) begin
                  bitCnt_nxt = bitCnt_r + 4'h1;
               end else if (sclFall) begin
                  if (byteDone) begin
                     pull_nxt  = 1'b0;
                     state_nxt = fsr_pkg::SLV_TXACK;
                  end else begin
                     pull_nxt  = ~shift_r[7];
                     shift_nxt = {shift_r[6:0], 1'b0};
                  end
               end
            end
            fsr_pkg::SLV_TXACK: begin
               // A NACK from the master ends the read; the STOP follows.
               if (sclRise) begin
                  state_nxt = (sdaNow == `FSR_BIT_NACK) ? fsr_pkg::SLV_IDLE : fsr_pkg::SLV_TXNEXT;
               end
            end
            default: begin
               state_nxt = fsr_pkg::SLV_IDLE;
            end
         endcase
      end
      if (state_nxt == fsr_pkg::SLV_ADDRACK) begin
         byteIdx_nxt = `FSR_IDX_CHK;
      end
   end

   // Bus idle level is high, so the synchronisers start high.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sclSync_r <= 2'h3;
         sdaSync_r <= 2'h3;
         sclPrev_r <= 1'b1;
         sdaPrev_r <= 1'b1;
      end else if (clkEn) begin
         sclSync_r <= {sclSync_r[0], bus.scl};
         sdaSync_r <= {sdaSync_r[0], bus.sda};
         sclPrev_r <= sclNow;
         sdaPrev_r <= sdaNow;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r   <= fsr_pkg::SLV_IDLE;
         bitCnt_r  <= 4'h0;
         shift_r   <= 8'h00;
         byteIdx_r <= 3'h0;
         dirRead_r <= 1'b0;
         pull_r    <= 1'b0;
      end else if (clkEn) begin
         state_r   <= state_nxt;
         bitCnt_r  <= bitCnt_nxt;
         shift_r   <= shift_nxt;
         byteIdx_r <= byteIdx_nxt;
         dirRead_r <= dirRead_nxt;
         pull_r    <= pull_nxt;
      end
   end

   // The oldest buffered measurement replaces the held one whenever the sensor is idle or taking in an address.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flow_r <= '0;
      end else if (clkEn && bufValid && !readActive) begin
         flow_r <= bufData;
      end
   end
endmodule

// ---- src/fsr_master.sv ----
// Purpose: Bus master end that reads the flow value from the sensor.
// Assumes: SCL is made here by dividing clk; no clock stretching by the slave.
// Notes:   Each bit takes four quarter periods; SDA moves one quarter after SCL falls.
`timescale 1ns/100ps
`include "fsr_defs.svh"
module fsr_master #(
   parameter int SCL_HZ = `FSR_SCL_HZ
) (
   input  wire logic            clk,
   input  wire logic            rst_n,
   input  wire logic            clkEn,
   fsr_if.master                bus,
   input  wire logic            rdReq,
   output logic                 rdBusy,
   output logic                 rdDone,
   output logic                 rdAddrNack,
   output logic                 rdSumOk,
   output logic [`FSR_FLOW_W-1:0] rdFlow
);
   // Rounded up so the bit rate never exceeds the chosen one.
   localparam int QTR = (`FSR_CLK_HZ + 4 * SCL_HZ - 1) / (4 * SCL_HZ);

   if (SCL_HZ > `FSR_SCL_MAX_HZ || QTR < `FSR_QTR_MIN || QTR > 65535) begin : g_chk
      $error("fsr_master SCL_HZ out of range for this clock");
   end

   fsr_pkg::fsr_mst_e state_r;
   fsr_pkg::fsr_mst_e state_nxt;
   logic [15:0] tmr_r;
   logic [1:0]  sdaSync_r;
   logic [1:0]  ph_r;
   logic [1:0]  ph_nxt;
   logic [3:0]  bitCnt_r;
   logic [3:0]  bitCnt_nxt;
   logic [2:0]  byteIdx_r;
   logic [2:0]  byteIdx_nxt;
   logic [7:0]  shift_r;
   logic [7:0]  shift_nxt;
   logic [7:0]  chk_r;
   logic [7:0]  chk_nxt;
   logic [7:0]  sum_r;
   logic [7:0]  sum_nxt;
   logic [`FSR_FLOW_W-1:0] flow_nxt;
   logic        scl_r;
   logic        scl_nxt;
   logic        pull_r;
   logic        pull_nxt;
   logic        nack_nxt;
   logic        done_nxt;
   logic        ok_nxt;

   wire       tick     = tmr_r == 16'(QTR - 1);
   wire       sdaIn    = sdaSync_r[1];
   wire       inByte   = bitCnt_r != `FSR_BITS;
   wire       addrByte = byteIdx_r == 3'h0;
   wire       lastByte = byteIdx_r == `FSR_IDX_LAST;
   wire [7:0] chkTotal = chk_r + sum_r;
   // Address bits are driven; data bits and the address ACK are left to the slave; data ACK low except last.
   wire       bitPull  = addrByte ? (inByte & ~shift_r[7]) :
                         (!inByte && !lastByte);

   assign rdBusy      = state_r != fsr_pkg::MST_IDLE;
   assign bus.scl     = scl_r;
   assign bus.sdaMOut = 1'b0;
   assign bus.sdaMOe  = pull_r;

   always_comb begin
      state_nxt   = state_r;
      ph_nxt      = ph_r;
      bitCnt_nxt  = bitCnt_r;
      byteIdx_nxt = byteIdx_r;
      shift_nxt   = shift_r;
      chk_nxt     = chk_r;
      sum_nxt     = sum_r;
      flow_nxt    = rdFlow;
      scl_nxt     = scl_r;
      pull_nxt    = pull_r;
      nack_nxt    = rdAddrNack;
      ok_nxt      = rdSumOk;
      done_nxt    = 1'b0;
      case (state_r)
         fsr_pkg::MST_IDLE: begin
            if (rdReq) begin
               pull_nxt    = 1'b1;
               state_nxt   = fsr_pkg::MST_START;
               shift_nxt   = {`FSR_DEV_ADDR, `FSR_DIR_READ};
               bitCnt_nxt  = 4'h0;
               byteIdx_nxt = 3'h0;
               sum_nxt     = 8'h00;
               nack_nxt    = 1'b0;
            end
         end
         fsr_pkg::MST_START: begin
            if (tick) begin
               scl_nxt   = 1'b0;
               ph_nxt    = 2'h0;
               state_nxt = fsr_pkg::MST_BIT;
            end
         end
         fsr_pkg::MST_BIT: begin
            if (tick) begin
               ph_nxt = ph_r + 2'h1;
               case (ph_r)
                  2'h0: pull_nxt = bitPull;
                  2'h1: scl_nxt = 1'b1;
                  2'h2: begin
                     if (inByte) begin
                        shift_nxt = {shift_r[6:0], sdaIn};
                     end else if (addrByte) begin
                        nack_nxt = sdaIn == `FSR_BIT_NACK;
                     end
                  end
                  default: begin
                     scl_nxt = 1'b0;
                     if (inByte) begin
                        bitCnt_nxt = bitCnt_r + 4'h1;
                     end else begin
                        bitCnt_nxt  = 4'h0;
                        byteIdx_nxt = byteIdx_r + 3'h1;
                        if (byteIdx_r == 3'h1) begin
                           chk_nxt = shift_r;
                        end else if (!addrByte) begin
                           sum_nxt = sum_r + shift_r;
                        end
                        if (byteIdx_r == 3'h2) begin
                           flow_nxt[11:8] = shift_r[3:0];
                        end
                        if (byteIdx_r == 3'h3) begin
                           flow_nxt[7:0] = shift_r;
                        end
                        if (lastByte || (addrByte && rdAddrNack)) begin
                           state_nxt = fsr_pkg::MST_STOP;
                        end
                     end
                  end
               endcase
            end
         end
         default: begin
            if (tick) begin
               ph_nxt = ph_r + 2'h1;
               case (ph_r)
                  2'h0: pull_nxt = 1'b1;
                  2'h1: scl_nxt = 1'b1;
                  2'h2: pull_nxt = 1'b0;
                  default: begin
                     state_nxt = fsr_pkg::MST_IDLE;
                     done_nxt  = 1'b1;
                     ok_nxt    = !rdAddrNack && chkTotal == `FSR_CHK_OK;
                  end
               endcase
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sdaSync_r <= 2'h3;
         tmr_r     <= 16'h0000;
      end else if (clkEn) begin
         sdaSync_r <= {sdaSync_r[0], bus.sda};
         tmr_r     <= (tick || state_r == fsr_pkg::MST_IDLE) ? 16'h0000 : tmr_r + 16'h0001;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r    <= fsr_pkg::MST_IDLE;
         ph_r       <= 2'h0;
         bitCnt_r   <= 4'h0;
         byteIdx_r  <= 3'h0;
         shift_r    <= 8'h00;
         chk_r      <= 8'h00;
         sum_r      <= 8'h00;
         rdFlow     <= '0;
         scl_r      <= 1'b1;
         pull_r     <= 1'b0;
         rdAddrNack <= 1'b0;
         rdSumOk    <= 1'b0;
         rdDone     <= 1'b0;
      end else if (clkEn) begin
         state_r    <= state_nxt;
         ph_r       <= ph_nxt;
         bitCnt_r   <= bitCnt_nxt;
         byteIdx_r  <= byteIdx_nxt;
         shift_r    <= shift_nxt;
         chk_r      <= chk_nxt;
         sum_r      <= sum_nxt;
         rdFlow     <= flow_nxt;
         scl_r      <= scl_nxt;
         pull_r     <= pull_nxt;
         rdAddrNack <= nack_nxt;
         rdSumOk    <= ok_nxt;
         rdDone     <= done_nxt;
      end
   end
endmodule

// ---- verification/fsr_link_asserts.sv ----
// Purpose: Concurrent checks on the two-wire link that joins master and sensor.
// Assumes: The master runs at 400 kHz or slower on a 50 MHz clk.
// Notes:   Bit positions are counted in SCL rises since the last START.
`timescale 1ns/100ps
module fsr_link_asserts (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic scl,
   input wire logic sdaMOe,
   input wire logic sdaSOe,
   input wire logic sda
);
   logic [7:0] sinceRise_r;
   logic [5:0] riseCnt_r;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // Saturating counters keep the idle time between frames from wrapping into a false short period.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sinceRise_r <= 8'hFF;
         riseCnt_r   <= 6'h00;
      end else begin
         if ($rose(scl)) sinceRise_r <= 8'h00;
         else if (sinceRise_r != 8'hFF) sinceRise_r <= sinceRise_r + 8'h01;
         if ($fell(sda) && scl && $past(scl)) riseCnt_r <= 6'h00;
         else if ($rose(scl) && riseCnt_r != 6'h3F) riseCnt_r <= riseCnt_r + 6'h01;
      end
   end

   a_slave_hold: assert property (scl && $past(scl) |-> $stable(sdaSOe))
      else $error("slave moved SDA while SCL was high");
   a_scl_low: assert property ($fell(scl) |=> !scl [*8])
      else $error("SCL low phase too short");
   a_scl_high: assert property ($rose(scl) |=> scl [*8])
      else $error("SCL high phase too short");
   a_bit_period: assert property ($rose(scl) |-> sinceRise_r >= 8'h78)
      else $error("SCL period shorter than the fastest bit rate");
   a_start_form: assert property ($fell(sda) && scl && $past(scl) |-> $rose(sdaMOe))
      else $error("SDA fell under high SCL without a master START");
   a_stop_form: assert property ($rose(sda) && scl && $past(scl) |-> $fell(sdaMOe))
      else $error("SDA rose under high SCL without a master STOP");
   a_addr_ack: assert property ($rose(scl) && riseCnt_r == 6'h08 |-> sdaSOe && !sda)
      else $error("address byte not acknowledged by the sensor");
   a_master_acks: assert property ($rose(scl) && riseCnt_r inside {6'h11, 6'h1A, 6'h23, 6'h2C}
      |-> sdaMOe && !sdaSOe)
      else $error("master did not acknowledge a middle byte");
   a_last_nack: assert property ($rose(scl) && riseCnt_r == 6'h35 |-> !sdaMOe && !sdaSOe && sda)
      else $error("last byte not answered by a released line");

   c_start: cover property ($fell(sda) && scl);
   c_last_byte: cover property ($rose(scl) && riseCnt_r == 6'h35);
   c_stop: cover property ($rose(sda) && scl);
endmodule

// ---- verification/tb_top.sv ----
// Purpose: Self-checking bench for both ends of the flow sensor read-out port.
// Assumes: Master at 400 kHz; a second sensor end is driven by hand at a 160 ns SCL.
// Notes:   A monitor rebuilds bytes and response bits from the wire at each SCL rise.
`timescale 1ns/100ps
`include "fsr_defs.svh"
module tb_top;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        clkEn = 1'b1;
   logic        rdReq = 1'b0;
   logic [11:0] measData = 12'h000;
   logic        measValid = 1'b0;
   wire         measReady, measReadyB, readActive, rdBusy, rdDone, rdAddrNack, rdSumOk;
   wire  [11:0] rdFlow;
   int          bad_count = 0;
   int          total_checks = 0;
   int          nBits = 0;
   logic [8:0]  shift;
   logic [7:0]  wireByte [0:7];
   logic [7:0]  wireAck;

   fsr_if u_fsr_if ();
   fsr_if u_fsr_if_b ();
   fsr_master #(.SCL_HZ(400000)) u_fsr_master (.clk(clk), .rst_n(rst_n), .clkEn(clkEn), .bus(u_fsr_if.master),
      .rdReq(rdReq), .rdBusy(rdBusy), .rdDone(rdDone), .rdAddrNack(rdAddrNack), .rdSumOk(rdSumOk), .rdFlow(rdFlow));
   fsr_slave u_fsr_slave (.clk(clk), .rst_n(rst_n), .clkEn(clkEn), .bus(u_fsr_if.slave), .measData(measData),
      .measValid(measValid), .measReady(measReady), .readActive(readActive));
   fsr_slave u_fsr_slave_b (.clk(clk), .rst_n(rst_n), .clkEn(clkEn), .bus(u_fsr_if_b.slave), .measData(measData),
      .measValid(measValid), .measReady(measReadyB), .readActive());
   fsr_link_asserts u_fsr_link_asserts (.clk(clk), .rst_n(rst_n), .scl(u_fsr_if.scl), .sdaMOe(u_fsr_if.sdaMOe),
      .sdaSOe(u_fsr_if.sdaSOe), .sda(u_fsr_if.sda));

   always #10 clk = ~clk;

   always @(negedge u_fsr_if.sda) if (u_fsr_if.scl === 1'b1) nBits = 0;
   always @(posedge u_fsr_if.scl) begin
      shift = {shift[7:0], u_fsr_if.sda};
      nBits = nBits + 1;
      if (nBits % 9 == 0 && nBits <= 72) begin
         wireByte[nBits/9-1] = shift[8:1];
         wireAck[nBits/9-1]  = shift[0];
      end
   end

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic summarize;
      $display("checks=%0d mismatches=%0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic offer(input logic [11:0] w);
      int n;
      @(negedge clk);
      measData  = w;
      measValid = 1'b1;
      n = 0;
      while (measReady !== 1'b1 && n < 20000) begin @(negedge clk); n++; end
      @(negedge clk);
      measValid = 1'b0;
   endtask

   task automatic doRead;
      int n;
      @(negedge clk);
      rdReq = 1'b1;
      @(negedge clk);
      rdReq = 1'b0;
      n = 0;
      while (rdDone !== 1'b1 && n < 20000) begin @(negedge clk); n++; end
      check(16'(rdDone), 16'h0001);
   endtask

   task automatic judge(input logic [11:0] f);
      logic [7:0] hi;
      logic [7:0] chk;
      hi  = {`FSR_HI_PAD, f[11:8]};
      chk = 8'h00 - ((hi + f[7:0]) << 1);
      doRead();
      check(16'(rdFlow), 16'(f));
      check(16'(rdSumOk), 16'h0001);
      check(16'(rdAddrNack), 16'h0000);
      check(16'(wireByte[0]), 16'({`FSR_DEV_ADDR, `FSR_DIR_READ}));
      check(16'(wireByte[1]), 16'(chk));
      check(16'(wireByte[2]), 16'(hi));
      check(16'(wireByte[3]), 16'(f[7:0]));
      check(16'({wireByte[4], wireByte[5]}), 16'({hi, f[7:0]}));
      check(16'(wireAck[0]), 16'h0000);
      check(16'(wireAck[5]), 16'h0001);
      // Six transfers of nine bits take 54 SCL rises, and the STOP lifts SCL once more.
      check(16'(nBits), 16'd55);
   endtask

   task automatic t_reset;
      check(16'({u_fsr_if.scl, measReady, rdBusy, rdDone, readActive}), 16'h0018);
   endtask

   task automatic t_values;
      logic [11:0] vals [0:2];
      vals = '{12'hABC, 12'hFFF, 12'h001};
      foreach (vals[i]) begin
         offer(vals[i]);
         repeat (4) @(negedge clk);
         judge(vals[i]);
      end
   endtask

   // Words offered during a read pile up in the buffer; the newest must win once the read ends.
   task automatic t_stall;
      int n;
      fork
         doRead();
         begin
            n = 0;
            while (readActive !== 1'b1 && n < 5000) begin @(negedge clk); n++; end
            offer(12'h123);
            offer(12'h456);
            @(negedge clk);
            measData  = 12'h789;
            measValid = 1'b1;
            repeat (2) @(negedge clk);
            check(16'(measReady), 16'h0000);
         end
      join
      @(negedge clk);
      measValid = 1'b0;
      repeat (4) @(negedge clk);
      judge(12'h789);
   endtask

   // Hand-driven write header on the second link; only the sensor's own address may be answered.
   task automatic probe(input logic [6:0] a, input logic expAck);
      logic [7:0] b;
      logic       got;
      b = {a, 1'b0};
      @(negedge clk);
      u_fsr_if_b.sdaMOe = 1'b1;
      repeat (4) @(negedge clk);
      u_fsr_if_b.scl = 1'b0;
      for (int i = 0; i < 9; i++) begin
         repeat (2) @(negedge clk);
         u_fsr_if_b.sdaMOe = (i < 8) ? ~b[7-i] : 1'b0;
         repeat (2) @(negedge clk);
         u_fsr_if_b.scl = 1'b1;
         repeat (4) @(negedge clk);
         got = u_fsr_if_b.sda;
         u_fsr_if_b.scl = 1'b0;
      end
      repeat (2) @(negedge clk);
      u_fsr_if_b.sdaMOe = 1'b1;
      repeat (2) @(negedge clk);
      u_fsr_if_b.scl = 1'b1;
      repeat (4) @(negedge clk);
      u_fsr_if_b.sdaMOe = 1'b0;
      check(16'(got), 16'(expAck));
   endtask

   task automatic t_addr;
      probe(7'h50, 1'b0);
      probe(7'h51, 1'b1);
      probe(7'h28, 1'b1);
   endtask

   initial begin
      u_fsr_if_b.scl     = 1'b1;
      u_fsr_if_b.sdaMOut = 1'b0;
      u_fsr_if_b.sdaMOe  = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      t_reset();
      judge(12'h000);
      t_values();
      t_stall();
      t_addr();
      summarize();
   end

   initial begin
      #2000000;
      bad_count++;
      summarize();
   end
endmodule
